//--- srx_params.svh
// Offsets, field positions, reset values and timing counts for the deserializer control
`ifndef SRX_PARAMS_SVH
`define SRX_PARAMS_SVH
`define SRX_CLK_MHZ      250
`define SRX_STOP_NS      1000
`define SRX_STOP_CYC     ((`SRX_STOP_NS * `SRX_CLK_MHZ + 999) / 1000)
`define SRX_IDLE_W       10
`define SRX_OFF_CTRL     4'h0
`define SRX_OFF_CFG      4'h4
`define SRX_OFF_THR      4'h8
`define SRX_OFF_STAT     4'hc
`define SRX_REGMODE_KEY  8'h01
`define SRX_CTRL_RST     32'h0000_0000
`define SRX_CFG_RST      32'h0000_0000
`define SRX_THR_RST      32'h0000_0408
`define SRX_B_EQ         0
`define SRX_B_SWING      1
`define SRX_B_OSS        2
`define SRX_B_FBSEL      3
`define SRX_OSC_LO       4
`define SRX_OSC_HI       5
`define SRX_SSC_LO       8
`define SRX_SSC_HI       11
`define SRX_B_LF         12
`define SRX_ACQ_LO       0
`define SRX_ACQ_HI       7
`define SRX_LOSS_LO      8
`define SRX_LOSS_HI      15
`define SRX_OSC_HALF     8'h04
`define SRX_DIV_HI0      12'h878
`define SRX_DIV_HI1      12'h514
`define SRX_DIV_HI2      12'h364
`define SRX_DIV_HI3      12'h28a
`define SRX_DIV_LF0      12'h26c
`define SRX_DIV_LF1      12'h172
`define SRX_DIV_LF2      12'h102
`define SRX_DIV_LF3      12'h0c0
`define SRX_RESP_OK      2'b00
`define SRX_RESP_SLVERR  2'b10
`endif

//--- srx_pkg.sv
// Types shared by the deserializer lock and output control
package srx_pkg;
  typedef enum logic {
    SRX_HUNT   = 1'b0,
    SRX_LOCKED = 1'b1
  } srx_lock_t;
  typedef enum logic [1:0] {
    SRX_SRC_LOW = 2'b00,
    SRX_SRC_REC = 2'b01,
    SRX_SRC_OSC = 2'b10
  } srx_csrc_t;
endpackage

//--- srx_rx_ctrl.sv
// Deserializer lock tracking, output state control and AXI4-Lite configuration
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "srx_params.svh"

module srx_rx_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        chip_enable_in,
  input  wire logic        output_drive_enable,
  input  wire logic        auto_detect_mode,
  input  wire logic        unlocked_output_state_select,
  input  wire logic        fallback_clock_select,
  input  wire logic        input_equalizer_boost_strap,
  input  wire logic        output_swing_select_strap,
  input  wire logic [3:0]  spread_setting_strap,
  input  wire logic        low_freq_range_strap,
  input  wire logic        self_test_result,
  input  wire logic        rx_clk,
  input  wire logic        frame_strobe,
  input  wire logic        embedded_clock_ok,
  input  wire logic [3:0]  rx_lane_in,
  output logic             lock_flag,
  output logic             parallel_clock_out,
  output logic             parallel_clock_oe,
  output logic [3:0]       parallel_lane_out,
  output logic             parallel_lane_oe,
  output logic             self_test_pass,
  output logic             self_test_pass_oe,
  output logic             input_equalizer_boost,
  output logic             output_swing_select,
  output logic             low_freq_range,
  output logic             spread_clock_generator_on,
  output logic [11:0]      spread_mod_div,
  output logic [1:0]       spread_dev_step,
  output logic             sleep_state,
  output logic             power_down_state
);

  // Pin synchronisers
  logic [11:0] pin_raw;
  logic [11:0] pin_s1;
  logic [11:0] pin_s2;
  assign pin_raw = {low_freq_range_strap, spread_setting_strap, output_swing_select_strap,
                    input_equalizer_boost_strap, fallback_clock_select,
                    unlocked_output_state_select, auto_detect_mode,
                    output_drive_enable, chip_enable_in};
  always_ff @(posedge aclk) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
  end
  logic en_s;
  logic oen_s;
  logic auto_s;
  assign en_s   = pin_s2[0];
  assign oen_s  = pin_s2[1];
  assign auto_s = pin_s2[2];

  // Stream activity seen from the bus clock
  logic                  frame_tgl;
  logic                  ftg_s1;
  logic                  ftg_s2;
  logic                  ftg_s3;
  logic [`SRX_IDLE_W-1:0] idle_cnt_reg;
  logic                  stopped_reg;
  logic                  pd_reg;
  logic                  frame_seen;
  always_ff @(posedge aclk) begin
    ftg_s1 <= frame_tgl;
    ftg_s2 <= ftg_s1;
    ftg_s3 <= ftg_s2;
  end
  assign frame_seen = ftg_s2 ^ ftg_s3;

  // The link clock may stop outright, so stop is judged on the bus clock
  always_ff @(posedge aclk) begin
    if (!aresetn || frame_seen) begin
      idle_cnt_reg <= '0;
      stopped_reg  <= 1'b0;
    end else if (idle_cnt_reg == `SRX_IDLE_W'(`SRX_STOP_CYC)) begin
      stopped_reg <= 1'b1;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      pd_reg <= 1'b1;
    else
      pd_reg <= !en_s || (auto_s && stopped_reg);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn)
      sleep_state <= 1'b0;
    else
      sleep_state <= en_s && !auto_s && stopped_reg;
  end
  assign power_down_state = pd_reg;

  // Registers; cleared by power down, kept through sleep
  logic [31:0] ctrl_reg;
  logic [31:0] cfg_reg;
  logic [31:0] thr_reg;
  logic        reg_clr;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [31:0] wmask;
  logic        do_wr;
  assign reg_clr = !aresetn || pd_reg;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_wr = aw_held && w_held && !s_axi_bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                  {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn || do_wr) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held     <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || do_wr) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held     <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SRX_RESP_OK;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_reg == `SRX_OFF_STAT) ? `SRX_RESP_SLVERR : `SRX_RESP_OK;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (reg_clr)
      ctrl_reg <= `SRX_CTRL_RST;
    else if (do_wr && aw_addr_reg == `SRX_OFF_CTRL)
      ctrl_reg <= (ctrl_reg & ~wmask) | (w_data_reg & wmask);
  end
  always_ff @(posedge aclk) begin
    if (reg_clr)
      cfg_reg <= `SRX_CFG_RST;
    else if (do_wr && aw_addr_reg == `SRX_OFF_CFG)
      cfg_reg <= (cfg_reg & ~wmask) | (w_data_reg & wmask);
  end
  always_ff @(posedge aclk) begin
    if (reg_clr)
      thr_reg <= `SRX_THR_RST;
    else if (do_wr && aw_addr_reg == `SRX_OFF_THR)
      thr_reg <= (thr_reg & ~wmask) | (w_data_reg & wmask);
  end

  // Pin or register configuration
  logic       reg_mode;
  logic       oss_eff;
  logic       fb_eff;
  logic [3:0] ssc_eff;
  logic       lf_eff;
  logic [7:0] acq_cfg;
  logic [7:0] loss_cfg;
  assign reg_mode = ctrl_reg[7:0] == `SRX_REGMODE_KEY;
  assign oss_eff = reg_mode ? cfg_reg[`SRX_B_OSS]   : pin_s2[3];
  assign fb_eff  = reg_mode ? cfg_reg[`SRX_B_FBSEL] : pin_s2[4];
  assign ssc_eff = reg_mode ? cfg_reg[`SRX_SSC_HI:`SRX_SSC_LO] : pin_s2[10:7];
  assign lf_eff  = reg_mode ? cfg_reg[`SRX_B_LF]    : pin_s2[11];
  assign acq_cfg  = thr_reg[`SRX_ACQ_HI:`SRX_ACQ_LO];
  assign loss_cfg = thr_reg[`SRX_LOSS_HI:`SRX_LOSS_LO];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_equalizer_boost <= 1'b0;
      output_swing_select   <= 1'b0;
      low_freq_range        <= 1'b0;
    end else begin
      input_equalizer_boost <= reg_mode ? cfg_reg[`SRX_B_EQ] : pin_s2[5];
      output_swing_select   <= reg_mode ? cfg_reg[`SRX_B_SWING] : pin_s2[6];
      low_freq_range        <= lf_eff;
    end
  end

  // Spread decode; one setting drives the clock modulation divider and step alike
  logic [3:0] ssc_m1;
  logic [11:0] div_sel;
  assign ssc_m1 = ssc_eff - 4'h1;
  always_comb begin
    unique case ({lf_eff, ssc_m1[3:2]})
      3'b000: div_sel = `SRX_DIV_HI0;
      3'b001: div_sel = `SRX_DIV_HI1;
      3'b010: div_sel = `SRX_DIV_HI2;
      3'b011: div_sel = `SRX_DIV_HI3;
      3'b100: div_sel = `SRX_DIV_LF0;
      3'b101: div_sel = `SRX_DIV_LF1;
      3'b110: div_sel = `SRX_DIV_LF2;
      3'b111: div_sel = `SRX_DIV_LF3;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || ssc_eff == 4'h0) begin
      spread_clock_generator_on <= 1'b0;
      spread_mod_div            <= (lf_eff) ? `SRX_DIV_LF0 : `SRX_DIV_HI0;
      spread_dev_step           <= 2'b00;
    end else begin
      spread_clock_generator_on <= 1'b1;
      spread_mod_div            <= div_sel;
      spread_dev_step           <= ssc_m1[1:0];
    end
  end

  // Link-side reset and thresholds; thresholds are static while hunting
  logic       lclr_src;
  logic       lclr_s1;
  logic       lclr_s2;
  logic       lrst_src;
  logic       lrst_s1;
  logic       lrst_s2;
  logic [15:0] thr_s1;
  logic [15:0] thr_s2;
  always_ff @(posedge aclk) begin
    lclr_src <= !aresetn || pd_reg || stopped_reg;
    lrst_src <= !aresetn;
  end
  always_ff @(posedge rx_clk) begin
    lclr_s1 <= lclr_src;
    lclr_s2 <= lclr_s1;
    lrst_s1 <= lrst_src;
    lrst_s2 <= lrst_s1;
    thr_s1  <= {loss_cfg, acq_cfg};
    thr_s2  <= thr_s1;
  end

  // Lock tracking on the recovered clock
  srx_pkg::srx_lock_t lk_state;
  logic [7:0] good_cnt;
  logic [7:0] bad_cnt;
  always_ff @(posedge rx_clk) begin
    if (lclr_s2) begin
      lk_state <= srx_pkg::SRX_HUNT;
      good_cnt <= '0;
      bad_cnt  <= '0;
    end else if (frame_strobe) begin
      unique case (lk_state)
        srx_pkg::SRX_HUNT: begin
          bad_cnt <= '0;
          if (!embedded_clock_ok)
            good_cnt <= '0;
          else if (good_cnt + 8'h01 >= thr_s2[7:0]) begin
            lk_state <= srx_pkg::SRX_LOCKED;
            good_cnt <= '0;
          end else
            good_cnt <= good_cnt + 8'h01;
        end
        srx_pkg::SRX_LOCKED: begin
          good_cnt <= '0;
          if (embedded_clock_ok)
            bad_cnt <= '0;
          else if (bad_cnt + 8'h01 >= thr_s2[15:8]) begin
            lk_state <= srx_pkg::SRX_HUNT;
            bad_cnt  <= '0;
          end else
            bad_cnt <= bad_cnt + 8'h01;
        end
      endcase
    end
  end
  always_ff @(posedge rx_clk) begin
    // Only reset stops it: a held toggle would leave stop and power down stuck
    if (lrst_s2)
      frame_tgl <= 1'b0;
    else if (frame_strobe)
      frame_tgl <= !frame_tgl;
  end
  always_ff @(posedge rx_clk) begin
    if (lclr_s2)
      parallel_lane_out <= 4'h0;
    else
      parallel_lane_out <= (lk_state == srx_pkg::SRX_LOCKED) ? rx_lane_in : 4'h0;
  end

  // Lock flag back to the bus clock
  logic lk_s1;
  logic lk_s2;
  always_ff @(posedge aclk) begin
    lk_s1 <= lk_state == srx_pkg::SRX_LOCKED;
    lk_s2 <= lk_s1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn)
      lock_flag <= 1'b0;
    else
      lock_flag <= lk_s2 && !stopped_reg && !pd_reg;
  end

  // Output enables from the state table
  // Of the power states only chip enable low forces every output to high impedance; auto power down follows the select
  logic ce_off_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ce_off_reg <= 1'b1;
    else
      ce_off_reg <= !en_s;
  end
  assign parallel_lane_oe  = !ce_off_reg && oen_s && (lock_flag || !oss_eff);
  assign parallel_clock_oe = !ce_off_reg && oen_s && (lock_flag || !oss_eff || fb_eff);
  assign self_test_pass_oe = !ce_off_reg && (lock_flag || !oss_eff);
  always_ff @(posedge aclk) begin
    if (!aresetn)
      self_test_pass <= 1'b1;
    else
      self_test_pass <= (oen_s && lock_flag) ? self_test_result : 1'b1;
  end

  // Fallback oscillator from the bus clock, rate chosen by register
  logic [7:0] osc_cnt;
  logic [7:0] osc_half;
  logic       osc_lvl;
  assign osc_half = `SRX_OSC_HALF << cfg_reg[`SRX_OSC_HI:`SRX_OSC_LO];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt <= '0;
      osc_lvl <= 1'b0;
    end else if (osc_cnt + 8'h01 >= osc_half) begin
      osc_cnt <= '0;
      osc_lvl <= !osc_lvl;
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
    end
  end

  // Recovered clock is sampled as a level; its edges jitter by one bus cycle
  logic rck_s1;
  logic rck_s2;
  always_ff @(posedge aclk) begin
    rck_s1 <= rx_clk;
    rck_s2 <= rck_s1;
  end

  srx_pkg::srx_csrc_t cur_src;
  srx_pkg::srx_csrc_t want_src;
  logic want_lvl;
  assign want_src = lock_flag ? srx_pkg::SRX_SRC_REC :
                    (fb_eff && oss_eff) ? srx_pkg::SRX_SRC_OSC : srx_pkg::SRX_SRC_LOW;
  always_comb begin
    unique case (want_src)
      srx_pkg::SRX_SRC_REC: want_lvl = rck_s2;
      srx_pkg::SRX_SRC_OSC: want_lvl = osc_lvl;
      default:              want_lvl = 1'b0;
    endcase
  end
  // Switch only once the new source matches the held level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_src            <= srx_pkg::SRX_SRC_LOW;
      parallel_clock_out <= 1'b0;
    end else if (cur_src == want_src || want_lvl == parallel_clock_out) begin
      cur_src            <= want_src;
      parallel_clock_out <= want_lvl;
    end
  end

  // Read channel
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      `SRX_OFF_CTRL: rd_val = ctrl_reg;
      `SRX_OFF_CFG:  rd_val = cfg_reg;
      `SRX_OFF_THR:  rd_val = thr_reg;
      `SRX_OFF_STAT: rd_val = {26'h0, spread_clock_generator_on, reg_mode,
                               stopped_reg, pd_reg, sleep_state, lock_flag};
      default:       rd_ok  = 1'b0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SRX_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? `SRX_RESP_OK : `SRX_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  sequence s_good_last;
    frame_strobe && embedded_clock_ok && lk_state == srx_pkg::SRX_HUNT
      && good_cnt + 8'h01 >= thr_s2[7:0];
  endsequence
  sequence s_bad_last;
    frame_strobe && !embedded_clock_ok && lk_state == srx_pkg::SRX_LOCKED
      && bad_cnt + 8'h01 >= thr_s2[15:8];
  endsequence
  sequence s_wr_pair;
    aw_held && w_held && !s_axi_bvalid;
  endsequence

  a_lock_acquire: assert property (@(posedge rx_clk) disable iff (lclr_s2)
    s_good_last |=> lk_state == srx_pkg::SRX_LOCKED) else $error("lock not acquired");
  a_lock_loss: assert property (@(posedge rx_clk) disable iff (lclr_s2)
    s_bad_last |=> lk_state == srx_pkg::SRX_HUNT) else $error("lock not dropped");
  a_flag_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (lk_s2 && !stopped_reg && !pd_reg) [*2] |-> lock_flag) else $error("lock flag missing");
  a_stop_unlock: assert property (@(posedge aclk) disable iff (!aresetn)
    stopped_reg |=> !lock_flag) else $error("lock held after stop");
  a_pd_regs_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    pd_reg |=> ctrl_reg == `SRX_CTRL_RST && thr_reg == `SRX_THR_RST)
    else $error("registers kept in power down");
  a_ce_low_tri: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_s |=> !parallel_clock_oe && !parallel_lane_oe && !self_test_pass_oe)
    else $error("outputs driven while disabled");
  a_oen_low_tri: assert property (@(posedge aclk) disable iff (!aresetn)
    !oen_s |-> !parallel_clock_oe && !parallel_lane_oe) else $error("drive while disabled");
  a_clk_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur_src != want_src && want_lvl != parallel_clock_out) |=> $stable(parallel_clock_out))
    else $error("clock glitch on switch");
  a_spread_code: assert property (@(posedge aclk) disable iff (!aresetn)
    ssc_eff == 4'h5 && !lf_eff |=> spread_mod_div == `SRX_DIV_HI1 && spread_dev_step == 2'b00)
    else $error("spread decode wrong");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr_pair |=> s_axi_bvalid) else $error("write not answered");

endmodule // srx_rx_ctrl

//--- srx_ser_model.sv
// Behavioural serializer model driving the recovered link side
`timescale 1ns/1ps
module srx_ser_model (
  input  wire logic       run,
  input  wire logic       good,
  output logic            rx_clk,
  output logic            frame_strobe,
  output logic            embedded_clock_ok,
  output logic [3:0]      rx_lane_in
);
  logic [3:0] cnt_reg;
  initial begin
    rx_clk = 1'b0;
    cnt_reg = 4'h0;
    #1.3;
    // Parks low when the stream stops, phase unrelated to the bus clock
    forever #3 rx_clk = (run || rx_clk) ? ~rx_clk : 1'b0;
  end
  always @(posedge rx_clk) begin
    cnt_reg <= cnt_reg + 4'h1;
  end
  // One frame per link clock; a stopped stream shows no stale marks
  assign frame_strobe = run;
  assign embedded_clock_ok = run & good;
  assign rx_lane_in = run ? cnt_reg : ~cnt_reg;
endmodule // srx_ser_model

//--- srx_rx_ctrl_tb_top.sv
// Self-checking bench for the deserializer lock and output control
`timescale 1ns/1ps
`include "srx_params.svh"
module srx_rx_ctrl_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, spread_dev_step;
  logic        chip_enable_in = 1'b0, output_drive_enable = 1'b1, auto_detect_mode = 1'b0;
  logic        unlocked_output_state_select = 1'b1, fallback_clock_select = 1'b0;
  logic        input_equalizer_boost_strap = 1'b1, output_swing_select_strap = 1'b0;
  logic        low_freq_range_strap = 1'b0, self_test_result = 1'b1, run = 1'b1, good = 1'b0;
  logic [3:0]  spread_setting_strap = 4'h5, rx_lane_in, parallel_lane_out;
  logic        rx_clk, frame_strobe, embedded_clock_ok, lock_flag, parallel_clock_out;
  logic        parallel_clock_oe, parallel_lane_oe, self_test_pass, self_test_pass_oe;
  logic        input_equalizer_boost, output_swing_select, low_freq_range;
  logic        spread_clock_generator_on, sleep_state, power_down_state;
  logic [11:0] spread_mod_div;
  logic [11:0] dv [8] = '{12'h878, 12'h514, 12'h364, 12'h28a, 12'h26c, 12'h172, 12'h102, 12'h0c0};
  int          bad_count = 0, tests_run = 0;

  always #2 aclk = ~aclk;

  srx_rx_ctrl u_srx_rx_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chip_enable_in, .output_drive_enable, .auto_detect_mode,
    .unlocked_output_state_select, .fallback_clock_select, .input_equalizer_boost_strap,
    .output_swing_select_strap, .spread_setting_strap, .low_freq_range_strap,
    .self_test_result, .rx_clk, .frame_strobe, .embedded_clock_ok, .rx_lane_in, .lock_flag,
    .parallel_clock_out, .parallel_clock_oe, .parallel_lane_out, .parallel_lane_oe,
    .self_test_pass, .self_test_pass_oe, .input_equalizer_boost, .output_swing_select,
    .low_freq_range, .spread_clock_generator_on, .spread_mod_div, .spread_dev_step,
    .sleep_state, .power_down_state);

  srx_ser_model u_srx_ser_model (.run, .good, .rx_clk, .frame_strobe, .embedded_clock_ok,
    .rx_lane_in);

  task print_verdict;
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Ends mid-cycle so levels are settled when compared
  task see(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, bd;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bd = 1'b0;
    while (!bd) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bd = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, rdone;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rdone = 1'b0;
    while (!rdone) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      rdone = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  function logic st(input int s);
    st = (s == 0) ? lock_flag : (s == 1) ? sleep_state : power_down_state;
  endfunction

  // Bounded wait on a status level, then compared
  task wt(input int s, input logic v, input int lim);
    int n;
    n = 0;
    @(negedge aclk);
    while (st(s) !== v && n < lim) begin
      @(negedge aclk);
      n++;
    end
    chk(st(s), v);
  endtask

  initial begin
    #80us;
    bad_count++;
    print_verdict();
  end

  initial begin
    // Reset held three cycles; power down keeps the link side clear after it
    cyc(3);
    aresetn <= 1'b1;
    see(6);
    chk({parallel_clock_oe, parallel_lane_oe, self_test_pass_oe}, 3'b000);
    chk(power_down_state, 1'b1);
    cyc(1);
    chip_enable_in <= 1'b1;
    see(8);
    chk({power_down_state, lock_flag}, 2'b00);
    chk({parallel_clock_oe, parallel_lane_oe, self_test_pass_oe}, 3'b000);
    chk({input_equalizer_boost, output_swing_select}, 2'b10);
    chk({spread_clock_generator_on, spread_mod_div, spread_dev_step}, {1'b1, 12'h514, 2'h0});
    cyc(1);
    fallback_clock_select <= 1'b1;
    see(6);
    chk(parallel_clock_oe, 1'b1);
    cyc(1);
    good <= 1'b1;
    see(3);
    chk(lock_flag, 1'b0);
    wt(0, 1'b1, 100);
    chk({parallel_clock_oe, parallel_lane_oe, self_test_pass_oe}, 3'b111);
    @(negedge rx_clk);
    chk(parallel_lane_out, 4'(rx_lane_in - 4'h1));
    cyc(1);
    self_test_result <= 1'b0;
    see(4);
    chk(self_test_pass, 1'b0);
    cyc(1);
    self_test_result <= 1'b1;
    output_drive_enable <= 1'b0;
    see(6);
    chk({parallel_clock_oe, parallel_lane_oe, self_test_pass_oe, self_test_pass}, 4'h3);
    cyc(1);
    output_drive_enable <= 1'b1;
    good <= 1'b0;
    wt(0, 1'b0, 100);
    chk(parallel_lane_oe, 1'b0);
    cyc(1);
    good <= 1'b1;
    wt(0, 1'b1, 100);
    cyc(1);
    wr(`SRX_OFF_CFG, 32'h0, rsp);
    see(4);
    chk(input_equalizer_boost, 1'b1);
    cyc(1);
    wr(`SRX_OFF_CTRL, 32'h1, rsp);
    see(4);
    chk(input_equalizer_boost, 1'b0);
    cyc(1);
    for (int l = 0; l < 2; l++) begin
      for (int c = 0; c < 16; c++) begin
        wr(`SRX_OFF_CFG, {19'h0, l[0], c[3:0], 8'h00}, rsp);
        see(3);
        chk({spread_clock_generator_on, low_freq_range}, {c != 0, l[0]});
        chk(spread_mod_div, dv[l * 4 + (c == 0 ? 0 : (c - 1) / 4)]);
        chk(spread_dev_step, (c == 0) ? 0 : (c - 1) % 4);
        cyc(1);
      end
    end
    rd(`SRX_OFF_THR, rdv, rsp);
    chk({rsp, rdv}, {2'b00, `SRX_THR_RST});
    cyc(1);
    rd(4'h2, rdv, rsp);
    chk({rsp, rdv}, {2'b10, 32'h0});
    wr(`SRX_OFF_STAT, 32'hffff_ffff, rsp);
    chk(rsp, 2'b10);
    rd(`SRX_OFF_STAT, rdv, rsp);
    chk({rdv[4], rdv[0]}, 2'b11);
    wr(`SRX_OFF_THR, 32'h0000_0305, rsp);
    run <= 1'b0;
    wt(1, 1'b1, 400);
    chk(lock_flag, 1'b0);
    cyc(1);
    rd(`SRX_OFF_THR, rdv, rsp);
    chk(rdv, 32'h0000_0305);
    run <= 1'b1;
    wt(0, 1'b1, 300);
    cyc(1);
    auto_detect_mode <= 1'b1;
    run <= 1'b0;
    wt(2, 1'b1, 400);
    cyc(1);
    rd(`SRX_OFF_THR, rdv, rsp);
    chk(rdv, `SRX_THR_RST);
    cyc(1);
    rd(`SRX_OFF_CTRL, rdv, rsp);
    chk(rdv, 32'h0);
    see(1);
    chk({parallel_clock_oe, parallel_lane_oe, lock_flag}, 3'b100);
    // Fallback runs at four bus cycles per half period after the clear
    rdv[0] = parallel_clock_out;
    see(4);
    chk(parallel_clock_out, !rdv[0]);
    cyc(1);
    run <= 1'b1;
    wt(0, 1'b1, 600);
    chk(power_down_state, 1'b0);
    cyc(1);
    chip_enable_in <= 1'b0;
    see(6);
    chk({parallel_clock_oe, parallel_lane_oe, self_test_pass_oe}, 3'b000);
    print_verdict();
  end
endmodule // srx_rx_ctrl_tb_top
